//--- lcdsc_params.svh
`ifndef LCDSC_PARAMS_SVH
`define LCDSC_PARAMS_SVH
// Register addresses on the plain register port
`define LCDSC_ADDR_W 10
`define LCDSC_OFF_CLK_DIV 10'h020
`define LCDSC_OFF_PRESCALER 10'h023
`define LCDSC_OFF_LCD_CONTROL 10'h03a
`define LCDSC_OFF_COM_SCAN 10'h03b
`define LCDSC_RAM_BASE 10'h200
`define LCDSC_RAM_LAST 10'h227
// Reset values
`define LCDSC_CLK_DIV_RST 3'h4
`define LCDSC_PRESCALER_RST 3'h0
`define LCDSC_LCD_CONTROL_RST 6'h00
`define LCDSC_COM_SCAN_RST 4'h0
// Control register fields
`define LCDSC_CTL_POWER_OFF 7
`define LCDSC_CTL_BLANK 6
`define LCDSC_CTL_COM_REUSE 5
`define LCDSC_CTL_ENH_DRIVE 4
`define LCDSC_CTL_SEG_REUSE 3
`define LCDSC_CTL_DUTY 0
// Prescaler fields
`define LCDSC_PRS_CLEAR 7
`define LCDSC_PRS_ENABLE 6
`define LCDSC_PRS_TIMER_EN 5
// Panel geometry
`define LCDSC_NUM_SEG 40
`define LCDSC_NUM_COM 8
// Frame divide for code 0; each next code halves it
`define LCDSC_FRAME_DIV_MAX 16384
`define LCDSC_DIV_W 14
`endif

//--- lcdsc_pkg.sv
`default_nettype none
package lcdsc_pkg;
  typedef enum logic {
    LCDSC_DUTY_QUARTER,
    LCDSC_DUTY_EIGHTH
  } lcdsc_duty_t;
endpackage
`default_nettype wire

//--- lcdsc_prescaler.sv
`include "lcdsc_params.svh"
`default_nettype none
// Divides the timer clock into per-common scan ticks
module lcdsc_prescaler (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic timer_clock_i,
  input wire logic enable_i,
  input wire logic clear_i,
  input wire logic [2:0] div_sel_i,
  input wire logic eighth_i,
  output logic tick_o
);
  logic [`LCDSC_DIV_W-1:0] cnt_r;
  logic [`LCDSC_DIV_W-1:0] limit;
  logic timer_clock_d_r;
  logic timer_clock_rise;

  assign timer_clock_rise = timer_clock_i & ~timer_clock_d_r;

  // Frame period halved per code, then split over the commons
  always_comb begin
    // Shift amount kept four bits wide so codes 6 and 7 cannot wrap
    limit = `LCDSC_DIV_W'(`LCDSC_FRAME_DIV_MAX >> ({1'b0, div_sel_i} + (eighth_i ? 4'h3 : 4'h2)));
    limit = limit - `LCDSC_DIV_W'(1);
  end

  // Edge detect of the timer clock
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_clock_d_r <= 1'b0;
    end else begin
      timer_clock_d_r <= timer_clock_i;
    end
  end

  // Count timer clock edges into a scan tick
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (clear_i || !enable_i) begin
        cnt_r <= '0;
      end else if (timer_clock_rise) begin
        if (cnt_r >= limit) begin
          cnt_r <= '0;
          tick_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r + `LCDSC_DIV_W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- lcdsc_top.sv
// How it works
// R1 - Duty bit picks 1/4 or 1/8 multiplex
// R2 - Forty segments, eight commons, byte per segment
// R3 - Display memory has no reset
// R4 - Bit 0 one means 1/8 duty
// R5 - Divider code sets frame clock rate
// R6 - Divider field resets to 100, readable
// R7 - Software sets prescaler enable to run
// R8 - Bit 7 one switches panel power off
// R9 - Bit 6 blanks segments, scanning continues
// R10 - Bit 5 frees commons four to seven
// R11 - 1/8 reuse: upper commons follow scan port
// R12 - Bit 4 selects enhanced drive
// R13 - Bit 3 frees segments zero to three
// R14 - Control register write-only, resets zero
// R15 - Segment n at 200H plus n
// R16 - 1/4 duty ignores upper four bits
// R17 - Memory readable and writable anytime
// R18 - Commons activate in turn, segments follow bits
`include "lcdsc_params.svh"
`default_nettype none
module lcdsc_top (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic timer_clock_i,
  input wire logic [`LCDSC_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic [`LCDSC_NUM_SEG-1:0] segment_outputs_o,
  output logic [`LCDSC_NUM_COM-1:0] common_outputs_o,
  output logic [3:0] seg_gpo_o,
  output logic [3:0] com_gpo_o,
  output logic panel_power_off_o,
  output logic enhanced_drive_o,
  output logic eighth_duty_o
);
  logic rst_s1_r;
  logic rst_n;
  logic [2:0] clk_div_r;
  logic [2:0] prescaler_r;
  logic [5:0] ctl_r;
  logic [3:0] com_scan_r;
  logic [7:0] ram_r [0:`LCDSC_NUM_SEG-1];
  logic [2:0] com_idx_r;
  logic tick;
  logic ram_hit;
  logic [5:0] ram_idx;
  lcdsc_pkg::lcdsc_duty_t duty;
  logic power_off;
  logic blank;
  logic com_reuse;
  logic seg_reuse;
  logic [`LCDSC_NUM_SEG-1:0] seg_nxt;
  logic [`LCDSC_NUM_COM-1:0] com_nxt;

  // Reset release through two flops
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // R15 address decode
  function automatic logic in_ram(input logic [`LCDSC_ADDR_W-1:0] a);
    in_ram = (a >= `LCDSC_RAM_BASE) && (a <= `LCDSC_RAM_LAST);
  endfunction

  assign ram_hit = in_ram(addr_i);
  assign ram_idx = 6'(addr_i - `LCDSC_RAM_BASE);

  // Control fields; ctl_r holds bits 7..3 and bit 0
  assign power_off = ctl_r[5];
  assign blank = ctl_r[4];
  assign com_reuse = ctl_r[3];
  assign seg_reuse = ctl_r[1];
  // R4 duty select
  assign duty = ctl_r[0] ? lcdsc_pkg::LCDSC_DUTY_EIGHTH : lcdsc_pkg::LCDSC_DUTY_QUARTER;

  // R6 divider select register
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clk_div_r <= `LCDSC_CLK_DIV_RST;
    end else if (wr_i && addr_i == `LCDSC_OFF_CLK_DIV) begin
      clk_div_r <= wdata_i[2:0];
    end
  end

  // Prescaler control; clear bit acts as a one-cycle pulse
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_r <= `LCDSC_PRESCALER_RST;
    end else if (wr_i && addr_i == `LCDSC_OFF_PRESCALER) begin
      prescaler_r <= wdata_i[7:5];
    end else begin
      prescaler_r[2] <= 1'b0;
    end
  end

  // R14 write-only control register
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= `LCDSC_LCD_CONTROL_RST;
    end else if (wr_i && addr_i == `LCDSC_OFF_LCD_CONTROL) begin
      ctl_r <= {wdata_i[7:3], wdata_i[`LCDSC_CTL_DUTY]};
    end
  end

  // Common scan port for reused upper commons
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      com_scan_r <= `LCDSC_COM_SCAN_RST;
    end else if (wr_i && addr_i == `LCDSC_OFF_COM_SCAN) begin
      com_scan_r <= wdata_i[3:0];
    end
  end

  // R3 R17 display memory, no reset, access at any time
  always_ff @(posedge core_clk_i) begin
    if (wr_i && ram_hit) begin
      ram_r[ram_idx] <= wdata_i;
    end
  end

  // Read data one cycle after the strobe; control reads zero
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (ram_hit) begin
        // R17 memory read
        rdata_o <= ram_r[ram_idx];
      end else if (addr_i == `LCDSC_OFF_CLK_DIV) begin
        rdata_o <= {5'h00, clk_div_r};
      end else if (addr_i == `LCDSC_OFF_PRESCALER) begin
        rdata_o <= {prescaler_r, 5'h00};
      end else if (addr_i == `LCDSC_OFF_COM_SCAN) begin
        rdata_o <= {4'h0, com_scan_r};
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // R5 R7 scan tick from the timer clock
  lcdsc_prescaler u_prescaler (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .timer_clock_i(timer_clock_i),
    .enable_i(prescaler_r[1]),
    .clear_i(prescaler_r[2]),
    .div_sel_i(clk_div_r),
    .eighth_i(ctl_r[0]),
    .tick_o(tick)
  );

  // R1 R18 common sequencer wraps at the duty length
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      com_idx_r <= 3'h0;
    end else if (tick) begin
      if (duty == lcdsc_pkg::LCDSC_DUTY_EIGHTH) begin
        com_idx_r <= com_idx_r + 3'h1;
      end else begin
        com_idx_r <= {1'b0, com_idx_r[1:0] + 2'h1};
      end
    end
  end

  // Segment and common levels for the current common
  always_comb begin
    seg_nxt = '0;
    com_nxt = '0;
    // R2 R18 each segment takes bit of its byte
    for (int s = 0; s < `LCDSC_NUM_SEG; s++) begin
      seg_nxt[s] = ram_r[s][com_idx_r];
    end
    com_nxt[com_idx_r] = 1'b1;
    // R16 upper bits unused at quarter duty
    if (duty == lcdsc_pkg::LCDSC_DUTY_QUARTER) begin
      com_nxt[7:4] = 4'h0;
    end
    // R9 blank segments, commons keep scanning
    if (blank) begin
      seg_nxt = '0;
    end
    // R13 segment pins zero to three as outputs
    if (seg_reuse) begin
      seg_nxt[3:0] = 4'h0;
    end
    // R10 R11 upper commons as outputs
    if (com_reuse) begin
      com_nxt[7:4] = 4'h0;
    end
    // R8 power off silences the panel
    if (power_off) begin
      seg_nxt = '0;
      com_nxt = '0;
    end
  end

  // Registered panel drive
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      segment_outputs_o <= '0;
      common_outputs_o <= '0;
      seg_gpo_o <= 4'h0;
      com_gpo_o <= 4'h0;
    end else begin
      segment_outputs_o <= seg_nxt;
      common_outputs_o <= com_nxt;
      // R13 general outputs take segment bytes bit 0
      for (int g = 0; g < 4; g++) begin
        seg_gpo_o[g] <= seg_reuse & ram_r[g][0];
      end
      // R11 reused upper commons follow scan port
      com_gpo_o <= com_reuse ? com_scan_r : 4'h0;
    end
  end

  // R8 R12 status pins for the analog drive
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      panel_power_off_o <= 1'b0;
      enhanced_drive_o <= 1'b0;
      eighth_duty_o <= 1'b0;
    end else begin
      panel_power_off_o <= power_off;
      // Bit 4 sits at ctl_r[2] after packing bits 7..3 above the duty bit
      enhanced_drive_o <= ctl_r[`LCDSC_CTL_ENH_DRIVE - 2];
      eighth_duty_o <= ctl_r[0];
    end
  end
endmodule
`default_nettype wire

//--- lcdsc_properties.sv
`include "lcdsc_params.svh"
`default_nettype none
module lcdsc_checker (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [`LCDSC_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [`LCDSC_NUM_SEG-1:0] segment_outputs_o,
  input wire logic [`LCDSC_NUM_COM-1:0] common_outputs_o,
  input wire logic panel_power_off_o,
  input wire logic enhanced_drive_o,
  input wire logic eighth_duty_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // Bus steps the properties start from
  sequence s_ctl_wr;
    wr_i && addr_i == `LCDSC_OFF_LCD_CONTROL;
  endsequence
  sequence s_rd(logic [9:0] a);
    rd_i && addr_i == a;
  endsequence
  // Read data only in the answer cycle
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_ctl_hidden;
    s_rd(`LCDSC_OFF_LCD_CONTROL) |=> rdata_o == 8'h00;
  endproperty
  a_ctl_hidden: assert property (p_ctl_hidden) else $error("control read not zero");
  property p_div_width;
    s_rd(`LCDSC_OFF_CLK_DIV) |=> rdata_o[7:3] == 5'h00;
  endproperty
  a_div_width: assert property (p_div_width) else $error("divider upper bits set");
  // Control levels follow the written bits
  property p_power;
    s_ctl_wr |-> ##2 panel_power_off_o == $past(wdata_i[7], 2);
  endproperty
  a_power: assert property (p_power) else $error("power level wrong");
  property p_drive;
    s_ctl_wr |-> ##2 enhanced_drive_o == $past(wdata_i[4], 2);
  endproperty
  a_drive: assert property (p_drive) else $error("drive level wrong");
  property p_duty;
    s_ctl_wr |-> ##2 eighth_duty_o == $past(wdata_i[0], 2);
  endproperty
  a_duty: assert property (p_duty) else $error("duty level wrong");
  property p_dark;
    panel_power_off_o ##1 panel_power_off_o |-> segment_outputs_o == '0;
  endproperty
  a_dark: assert property (p_dark) else $error("segments lit while off");
  property p_one_com;
    $onehot0(common_outputs_o);
  endproperty
  a_one_com: assert property (p_one_com) else $error("several commons active");
endmodule
bind lcdsc_top lcdsc_checker lcdsc_checker_i (.core_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .segment_outputs_o, .common_outputs_o, .panel_power_off_o, .enhanced_drive_o, .eighth_duty_o);
`default_nettype wire

//--- lcdsc_panel.sv
`default_nettype none
// Glass model: keeps the last dot row seen under each common
module lcdsc_panel (
  input wire logic clk_i,
  input wire logic [39:0] seg_i,
  input wire logic [7:0] com_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [39:0] row [8];
  // Latch the row lit by the active common
  always @(posedge clk_i) begin
    for (int k = 0; k < 8; k++) begin
      if (com_i[k] === 1'b1) begin
        row[k] <= seg_i;
      end
    end
  end
endmodule
`default_nettype wire

//--- lcdsc_tb.sv
`include "lcdsc_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, timer_clock, wr, rd, rd_d, poff, enh, duty;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, com;
  logic [39:0] seg;
  logic [7:0] ram [40];
  logic [3:0] sgpo, cgpo, scan;
  logic [7:0] expq [$];
  int fails = 0;
  int checks = 0;
  int seed = 32'h8cda;
  lcdsc_top lcdsc_top_i (.core_clk_i(clk), .rstn_i(rstn), .timer_clock_i(timer_clock), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .segment_outputs_o(seg), .common_outputs_o(com), .seg_gpo_o(sgpo),
    .com_gpo_o(cgpo), .panel_power_off_o(poff), .enhanced_drive_o(enh), .eighth_duty_o(duty));
  lcdsc_panel lcdsc_panel_i (.clk_i(clk), .seg_i(seg), .com_i(com));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Timer clock rises every second core cycle; read answers checked in order
  always @(posedge clk) begin
    timer_clock <= ~timer_clock;
    rd_d <= rd;
    if (rd_d === 1'b1) begin
      cmp(40'(rdata), 40'(expq.pop_front()));
    end
  end
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [9:0] a, input logic [7:0] e);
    expq.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // Time one common, wait a frame, then compare every captured row
  task automatic scan_check(input int n, input int per);
    logic [7:0] c0;
    logic [39:0] e;
    int t;
    c0 = com;
    while (com === c0) @(posedge clk);
    c0 = com;
    t = 0;
    while (com === c0) begin
      @(posedge clk);
      t++;
    end
    cmp(40'(t), 40'(per));
    repeat (n * per + 8) @(posedge clk);
    for (int k = 0; k < n; k++) begin
      for (int s = 0; s < 40; s++) e[s] = ram[s][k];
      cmp(lcdsc_panel_i.row[k], e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  // Main sequence: reset values, memory, scan, control bits
  initial begin
    {rstn, timer_clock, wr, rd, rd_d, addr, wdata} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    cmp(40'({poff, enh, duty}), 40'h0);
    rd_reg(`LCDSC_OFF_CLK_DIV, 8'h04);
    rd_reg(`LCDSC_OFF_LCD_CONTROL, 8'h00);
    wr_reg(10'h228, 8'h5a);
    rd_reg(10'h228, 8'h00);
    for (int s = 0; s < 40; s++) begin
      ram[s] = 8'($random(seed));
      wr_reg(10'(`LCDSC_RAM_BASE + s), ram[s]);
    end
    for (int s = 0; s < 40; s++) rd_reg(10'(`LCDSC_RAM_BASE + s), ram[s]);
    wr_reg(`LCDSC_OFF_CLK_DIV, 8'hfa);
    rd_reg(`LCDSC_OFF_CLK_DIV, 8'h02);
    wr_reg(`LCDSC_OFF_PRESCALER, 8'h40);
    rd_reg(`LCDSC_OFF_PRESCALER, 8'h40);
    scan_check(4, 2048);
    wr_reg(`LCDSC_OFF_LCD_CONTROL, 8'h01);
    scan_check(8, 1024);
    wr_reg(`LCDSC_OFF_LCD_CONTROL, 8'h91);
    repeat (2) @(posedge clk);
    cmp(40'({poff, enh, duty}), 40'h7);
    cmp(seg, 40'h0);
    scan = 4'($random(seed));
    wr_reg(`LCDSC_OFF_COM_SCAN, {4'h0, scan});
    wr_reg(`LCDSC_OFF_LCD_CONTROL, 8'h29);
    repeat (2) @(posedge clk);
    cmp(40'(cgpo), 40'(scan));
    cmp(40'(sgpo), 40'({ram[3][0], ram[2][0], ram[1][0], ram[0][0]}));
    wr_reg(`LCDSC_OFF_LCD_CONTROL, 8'h40);
    repeat (2) @(posedge clk);
    scan = com[3:0];
    repeat (2100) @(posedge clk);
    cmp(seg, 40'h0);
    cmp(40'(com[3:0] !== scan), 40'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
